// File: logic/uss_top.v
// Serial unit top: APB registers, clocking, error and interrupt logic
`timescale 1ns/100ps
module uss_top (
  input wire clk_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire rxd_in,
  output reg txd_out,
  output reg irq_out
);
`include "uss_consts.vh"
  reg [7:0] mode_r;
  reg [3:0] psc_sel_r;
  reg [7:0] baud_r;
  reg [2:0] err_r;
  reg [7:0] rxbuf_r;
  reg rxfull_r;
  reg [2:0] irq_st_r;
  reg [2:0] irq_en_r;
  reg wait_r;
  reg [10:0] psc_r;
  reg tick_r;
  reg [1:0] txe_sync_r;
  reg [1:0] rxe_sync_r;
  reg rxd_m_r;
  reg rxd_s_r;
  wire tx_full;
  wire tx_busy;
  wire tx_txd;
  wire tx_done;
  wire rx_done;
  wire [7:0] rx_data;
  wire rx_pe;
  wire rx_fe;
  wire power = mode_r[`USS_F_POWER];
  wire acc = psel_in & penable_in;
  wire done = acc & pready_out;
  wire wr = done & pwrite_in;
  wire rd = done & ~pwrite_in;
  wire tx_wr = wr && paddr_in == `USS_A_TXBUF && txe_sync_r[1];
  wire [10:0] psc_top = (11'd1 << psc_sel_r) - 11'd1;
  wire err_clr = rd && paddr_in == `USS_A_ERR;
  wire drop = rxfull_r | (err_r[`USS_E_OVR] & ~err_clr);
  wire rx_err = rx_pe | rx_fe | drop;
  reg [2:0] irq_set;
  reg [31:0] rdata;
  reg mapped;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a <= `USS_A_IRQEN) && (a[1:0] == 2'b00);
    end
  endfunction

  // Two-flop synchroniser on the line input
  always @(posedge clk_in) begin
    if (rst_in) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd_in;
      rxd_s_r <= rxd_m_r;
    end
  end

  // Base clock: one-cycle enable every 2^sel peripheral clocks, 2^11 for sel 11 to 15
  always @(posedge clk_in) begin
    if (rst_in || !power) begin
      psc_r <= 11'd0;
      tick_r <= 1'b0;
    end else if (psc_r >= psc_top) begin
      psc_r <= 11'd0;
      tick_r <= 1'b1;
    end else begin
      psc_r <= psc_r + 11'd1;
      tick_r <= 1'b0;
    end
  end

  // Enables pass two base clocks; a quick re-enable may miss reset
  always @(posedge clk_in) begin
    if (rst_in || !power) begin
      txe_sync_r <= 2'b00;
      rxe_sync_r <= 2'b00;
    end else if (tick_r) begin
      txe_sync_r <= {txe_sync_r[0], mode_r[`USS_F_TXE]};
      rxe_sync_r <= {rxe_sync_r[0], mode_r[`USS_F_RXE]};
    end
  end

  uss_tx u_tx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(txe_sync_r[1]),
    .tick_in(tick_r),
    .div_in(baud_r),
    .len8_in(mode_r[`USS_F_LEN8]),
    .stop2_in(mode_r[`USS_F_STOP2]),
    .par_in(mode_r[`USS_F_PARH:`USS_F_PARL]),
    .wr_in(tx_wr),
    .data_in(pwdata_in[7:0]),
    .full_out(tx_full),
    .busy_out(tx_busy),
    .txd_out(tx_txd),
    .done_out(tx_done)
  );

  uss_rx u_rx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(rxe_sync_r[1]),
    .tick_in(tick_r),
    .div_in(baud_r),
    .len8_in(mode_r[`USS_F_LEN8]),
    .par_in(mode_r[`USS_F_PARH:`USS_F_PARL]),
    .rxd_in(rxd_s_r),
    .done_out(rx_done),
    .data_out(rx_data),
    .pe_out(rx_pe),
    .fe_out(rx_fe)
  );

  // Line output straight from a flop; idle high while unpowered
  always @(posedge clk_in) begin
    if (rst_in)
      txd_out <= 1'b1;
    else
      txd_out <= txe_sync_r[1] ? tx_txd : 1'b1;
  end

  // APB handshake; error status read gets one extra wait state
  always @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      wait_r <= 1'b0;
    end else if (acc && !pready_out) begin
      if (!pwrite_in && paddr_in == `USS_A_ERR && !wait_r) begin
        wait_r <= 1'b1;
      end else begin
        wait_r <= 1'b0;
        pready_out <= 1'b1;
        pslverr_out <= ~mapped;
      end
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  always @* begin
    rdata = 32'h0000_0000;
    mapped = is_mapped(paddr_in);
    if (paddr_in == `USS_A_MODE) begin
      rdata[7:0] = mode_r;
    end else if (paddr_in == `USS_A_ERR) begin
      rdata[2:0] = err_r;
    end else if (paddr_in == `USS_A_TXST) begin
      rdata[1:0] = {tx_full, tx_busy};
    end else if (paddr_in == `USS_A_RXBUF) begin
      rdata[7:0] = rxbuf_r;
    end else if (paddr_in == `USS_A_CLKSEL) begin
      rdata[3:0] = psc_sel_r;
    end else if (paddr_in == `USS_A_BAUD) begin
      rdata[7:0] = baud_r;
    end else if (paddr_in == `USS_A_IRQST) begin
      rdata[2:0] = irq_st_r;
    end else if (paddr_in == `USS_A_IRQEN) begin
      rdata[2:0] = irq_en_r;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in)
      prdata_out <= 32'h0000_0000;
    else if (acc && !pready_out)
      prdata_out <= rdata;
  end

  // Control registers; ordering of writes is left to software
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_r <= `USS_MODE_RST;
      psc_sel_r <= 4'h0;
      baud_r <= `USS_BAUD_RST;
      irq_en_r <= 3'b000;
    end else if (wr) begin
      if (paddr_in == `USS_A_MODE)
        mode_r <= pwdata_in[7:0];
      else if (paddr_in == `USS_A_CLKSEL)
        psc_sel_r <= pwdata_in[3:0];
      else if (paddr_in == `USS_A_BAUD && pwdata_in[7:0] != 8'h00)
        baud_r <= pwdata_in[7:0];
      else if (paddr_in == `USS_A_IRQEN)
        irq_en_r <= pwdata_in[2:0];
    end
  end

  // Receive buffer and error flags; errors clear on status read
  always @(posedge clk_in) begin
    if (rst_in || !rxe_sync_r[1]) begin
      err_r <= 3'b000;
      rxbuf_r <= 8'h00;
      rxfull_r <= 1'b0;
    end else begin
      if (err_clr)
        err_r <= 3'b000;
      if (rd && paddr_in == `USS_A_RXBUF)
        rxfull_r <= 1'b0;
      if (rx_done) begin
        // A new error survives a same-cycle status read
        err_r[`USS_E_PAR] <= rx_pe | (err_r[`USS_E_PAR] & ~err_clr);
        err_r[`USS_E_FRM] <= rx_fe | (err_r[`USS_E_FRM] & ~err_clr);
        if (drop) begin
          err_r[`USS_E_OVR] <= 1'b1;
        end else begin
          rxbuf_r <= rx_data;
          rxfull_r <= 1'b1;
        end
      end
    end
  end

  // Merge select routes errors to the receive-done event
  always @* begin
    irq_set = 3'b000;
    irq_set[`USS_I_TX] = tx_done;
    if (rx_done && rx_err) begin
      if (mode_r[`USS_F_MERGE])
        irq_set[`USS_I_RX] = 1'b1;
      else
        irq_set[`USS_I_ERR] = 1'b1;
    end else begin
      irq_set[`USS_I_RX] = rx_done;
    end
  end

  // Set beats clear in the same cycle
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_st_r <= 3'b000;
      irq_out <= 1'b0;
    end else begin
      if (wr && paddr_in == `USS_A_IRQCLR)
        irq_st_r <= (irq_st_r & ~pwdata_in[2:0]) | irq_set;
      else
        irq_st_r <= irq_st_r | irq_set;
      irq_out <= |(irq_st_r & irq_en_r);
    end
  end
endmodule

// File: logic/uss_consts.vh
// Constants for the serial unit: offsets, fields, resets, timing
`ifndef USS_CONSTS_VH
`define USS_CONSTS_VH
`define USS_A_MODE 12'h000
`define USS_A_ERR 12'h004
`define USS_A_TXST 12'h008
`define USS_A_RXBUF 12'h00c
`define USS_A_TXBUF 12'h010
`define USS_A_CLKSEL 12'h014
`define USS_A_BAUD 12'h018
`define USS_A_IRQST 12'h01c
`define USS_A_IRQCLR 12'h020
`define USS_A_IRQEN 12'h024
`define USS_F_POWER 7
`define USS_F_TXE 6
`define USS_F_RXE 5
`define USS_F_PARH 4
`define USS_F_PARL 3
`define USS_F_LEN8 2
`define USS_F_STOP2 1
`define USS_F_MERGE 0
`define USS_E_PAR 2
`define USS_E_FRM 1
`define USS_E_OVR 0
`define USS_I_RX 0
`define USS_I_ERR 1
`define USS_I_TX 2
`define USS_MODE_RST 8'h01
`define USS_BAUD_RST 8'h04
`define USS_PAR_NONE 2'b00
`define USS_PAR_ZERO 2'b01
`define USS_PAR_ODD 2'b10
`define USS_PAR_EVEN 2'b11
`define USS_EN_SYNC_STAGES 2
`endif

// File: logic/uss_tx.v
// Transmitter: buffer register, shifter and status flags
`timescale 1ns/100ps
module uss_tx (
  input wire clk_in,
  input wire rst_in,
  input wire en_in,
  input wire tick_in,
  input wire [7:0] div_in,
  input wire len8_in,
  input wire stop2_in,
  input wire [1:0] par_in,
  input wire wr_in,
  input wire [7:0] data_in,
  output reg full_out,
  output reg busy_out,
  output reg txd_out,
  output reg done_out
);
`include "uss_consts.vh"
  reg [7:0] buf_r;
  reg [11:0] sh_r;
  reg [3:0] left_r;
  reg [8:0] bc_r;
  wire [8:0] per = {div_in, 1'b0};
  wire par_bit = (par_in == `USS_PAR_EVEN) ? ^buf_r :
    (par_in == `USS_PAR_ODD) ? ~^buf_r : 1'b0;
  wire has_par = (par_in != `USS_PAR_NONE);
  wire [3:0] nbits = 4'd2 + (len8_in ? 4'd8 : 4'd7) +
    {3'b000, has_par} + {3'b000, stop2_in};
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in || !en_in) begin
      full_out <= 1'b0;
      busy_out <= 1'b0;
      txd_out <= 1'b1;
      left_r <= 4'd0;
      bc_r <= 9'd0;
      buf_r <= 8'h00;
      sh_r <= 12'hfff;
    end else begin
      if (wr_in) begin
        buf_r <= data_in;
        full_out <= 1'b1;
      end
      if (!busy_out && full_out && !wr_in) begin
        // Frame is built LSB first, padded with idle ones
        sh_r <= len8_in ? {2'b11, par_bit, buf_r, 1'b0} :
          {3'b111, par_bit, buf_r[6:0], 1'b0};
        if (!has_par && len8_in)
          sh_r[9] <= 1'b1;
        if (!has_par && !len8_in)
          sh_r[8] <= 1'b1;
        left_r <= nbits;
        full_out <= 1'b0;
        busy_out <= 1'b1;
        bc_r <= 9'd0;
      end else if (busy_out && tick_in) begin
        // Line moves only at a bit boundary, then holds a bit time
        if (bc_r == 9'd0) begin
          txd_out <= sh_r[0];
          sh_r <= {1'b1, sh_r[11:1]};
          left_r <= left_r - 4'd1;
        end
        if (bc_r == per - 9'd1) begin
          bc_r <= 9'd0;
          if (left_r == 4'd0) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end else begin
          bc_r <= bc_r + 9'd1;
        end
      end
    end
  end
endmodule

// File: logic/uss_rx.v
// Receiver: start detect, sampling, parity and stop checks
`timescale 1ns/100ps
module uss_rx (
  input wire clk_in,
  input wire rst_in,
  input wire en_in,
  input wire tick_in,
  input wire [7:0] div_in,
  input wire len8_in,
  input wire [1:0] par_in,
  input wire rxd_in,
  output reg done_out,
  output reg [7:0] data_out,
  output reg pe_out,
  output reg fe_out
);
`include "uss_consts.vh"
  reg act_r;
  reg [8:0] bc_r;
  reg [3:0] idx_r;
  reg [8:0] sh_r;
  wire [8:0] per = {div_in, 1'b0};
  wire [8:0] mid = {1'b0, div_in} - 9'd1;
  wire has_par = (par_in != `USS_PAR_NONE);
  wire [3:0] last = (len8_in ? 4'd8 : 4'd7) + {3'b000, has_par};
  wire [7:0] dat = len8_in ? sh_r[7:0] : {1'b0, sh_r[6:0]};
  wire pbit = len8_in ? sh_r[8] : sh_r[7];
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in || !en_in) begin
      act_r <= 1'b0;
      bc_r <= 9'd0;
      idx_r <= 4'd0;
      sh_r <= 9'd0;
      data_out <= 8'h00;
      pe_out <= 1'b0;
      fe_out <= 1'b0;
    end else if (tick_in) begin
      if (!act_r) begin
        bc_r <= 9'd0;
        idx_r <= 4'd0;
        if (!rxd_in)
          act_r <= 1'b1;
      end else begin
        if (bc_r == per - 9'd1)
          bc_r <= 9'd0;
        else
          bc_r <= bc_r + 9'd1;
        // Sample point apart from the wrap, so a two-tick bit still works
        if (bc_r == mid && idx_r == 4'd0 && rxd_in) begin
          act_r <= 1'b0; // Glitch, not a start bit
        end else if (bc_r == mid) begin
          idx_r <= idx_r + 4'd1;
          if (idx_r != 4'd0 && idx_r <= last)
            sh_r[idx_r - 4'd1] <= rxd_in;
          if (idx_r == last + 4'd1) begin
            // Only the first stop bit is looked at
            fe_out <= ~rxd_in;
            data_out <= dat;
            pe_out <= (par_in == `USS_PAR_ODD) ? ~(^dat ^ pbit) :
              (par_in == `USS_PAR_EVEN) ? (^dat ^ pbit) : 1'b0;
            done_out <= 1'b1;
            act_r <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// File: sim/uss_chk.sv
// Checker on the serial unit's bus and pin ports
`timescale 1ns/100ps
`include "uss_consts.vh"
module uss_chk (
  input wire clk_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire txd_out,
  input wire irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire go = psel_in && penable_in && !pready_out;
  wire bad = paddr_in[1:0] != 2'b00 || paddr_in > `USS_A_IRQEN;
  // First access edge only; the wait edge must not restart it
  property p_wait;
    go && !$past(penable_in) && !pwrite_in && paddr_in == `USS_A_ERR |=>
      !pready_out ##1 pready_out;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait on err read");
  property p_fast;
    go && !$past(penable_in) && (pwrite_in || paddr_in != `USS_A_ERR) |=>
      pready_out;
  endproperty
  a_fast: assert property (p_fast) else $error("late ready");
  property p_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_lone;
    pslverr_out |-> pready_out;
  endproperty
  a_lone: assert property (p_lone) else $error("error without ready");
  property p_refuse;
    pready_out && bad |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad address taken");
  property p_accept;
    pready_out && !bad |-> !pslverr_out;
  endproperty
  a_accept: assert property (p_accept) else $error("good address refused");
  // Reset level checks must run while reset is high
  property p_rst;
    disable iff (1'b0) rst_in |=> txd_out && !irq_out && !pready_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
endmodule
bind uss_top uss_chk i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .txd_out(txd_out), .irq_out(irq_out));

// File: sim/uss_peer.sv
// Remote serial node: sends frames, collects frames from the unit
`timescale 1ns/100ps
module uss_peer (
  input wire clk_in,
  input wire txd_in,
  output logic rxd_out
);
  localparam int BT = 2;
  logic [9:0] got [0:7];
  logic [9:0] sh;
  int n = 0;
  initial rxd_out = 1'b1;
  task automatic bit_out(input logic v);
    rxd_out <= v;
    repeat (BT) @(posedge clk_in);
  endtask
  // Line idles high; a bad stop is followed by idle
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    bit_out(p);
    bit_out(s);
    if (!s) bit_out(1'b1);
  endtask
  // Samples mid-bit: data, parity, first stop
  always begin
    @(negedge txd_in);
    @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      repeat (BT) @(posedge clk_in);
      sh[i] = txd_in;
    end
    got[n] = sh;
    n++;
  end
endmodule

// File: sim/tb.sv
// Bench: register, error flag, transmit and interrupt tests
`timescale 1ns/100ps
`include "uss_consts.vh"
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  wire [31:0] prdata_out;
  wire pready_out;
  wire pslverr_out;
  wire rxd_in;
  wire txd_out;
  wire irq_out;
  logic [31:0] rd;
  logic err_seen;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  uss_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out));
  uss_peer i_peer (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd_in));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One transfer, then an idle edge so the next never overlaps
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err_seen = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Interrupt output lags status by a cycle
  task automatic irqc(input logic exp);
    @(posedge clk_in);
    chk({31'h0, irq_out}, {31'h0, exp});
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(`USS_A_MODE, 32'h1);
    rdc(`USS_A_BAUD, 32'h4);
    rdc(`USS_A_ERR, 32'h0);
    rdc(12'h028, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    rdc(12'h002, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    wr(`USS_A_CLKSEL, 32'h0);
    wr(`USS_A_BAUD, 32'h1);
    wr(`USS_A_IRQEN, 32'h7);
    // Parity bit 1 on 0x01: wrong only in odd mode
    for (int m = 0; m < 4; m++) begin
      wr(`USS_A_MODE, 32'h86 | (m << 3));
      repeat (2) @(posedge clk_in);
      wr(`USS_A_MODE, 32'he6 | (m << 3));
      repeat (4) @(posedge clk_in);
      i_peer.send(8'h01, 1'b1, 1'b1);
      repeat (8) @(posedge clk_in);
      rdc(`USS_A_ERR, (m == 2) ? 32'h4 : 32'h0);
      rdc(`USS_A_RXBUF, 32'h1);
    end
    // Back to back, one stop each, with two stops configured
    i_peer.send(8'h3c, 1'b0, 1'b1);
    i_peer.send(8'h5a, 1'b0, 1'b1);
    i_peer.send(8'h66, 1'b0, 1'b1);
    repeat (8) @(posedge clk_in);
    rdc(`USS_A_ERR, 32'h1);
    rdc(`USS_A_RXBUF, 32'h3c);
    rdc(`USS_A_ERR, 32'h0);
    i_peer.send(8'h3c, 1'b0, 1'b0);
    repeat (8) @(posedge clk_in);
    rdc(`USS_A_ERR, 32'h2);
    apb(1'b0, `USS_A_RXBUF, 32'h0);
    wr(`USS_A_IRQCLR, 32'h7);
    wr(`USS_A_TXBUF, 32'ha5);
    rdc(`USS_A_TXST, 32'h1);
    wr(`USS_A_TXBUF, 32'h3c);
    rdc(`USS_A_TXST, 32'h3);
    do apb(1'b0, `USS_A_TXST, 32'h0); while (rd !== 32'h0);
    wait (i_peer.n == 2);
    chk({22'h0, i_peer.got[0]}, 32'h2a5);
    chk({22'h0, i_peer.got[1]}, 32'h23c);
    rdc(`USS_A_IRQST, 32'h4);
    irqc(1'b1);
    wr(`USS_A_IRQEN, 32'h3);
    irqc(1'b0);
    wr(`USS_A_IRQEN, 32'h7);
    irqc(1'b1);
    wr(`USS_A_IRQCLR, 32'h4);
    rdc(`USS_A_IRQST, 32'h0);
    irqc(1'b0);
    wrap_up();
  end
endmodule
